// ### rtl/acrb_regs.sv
`default_nettype none
// How it works
// - Registers update on write; override acts only after transfer
// - Transfer bit 0 copies override into active
// - Resolution code 01 gives 14, 10 gives 12
// - Rate codes 000..110 map 20..125 MSPS
// - Override limits capability, not sampling rate
// - Channel index selects per-channel register targets
// - Bit 5 picks pin standby or power-down
// - Power-down 00 keeps all channels active
// - Code 01 stops clocks, resets, disables outputs
// - Code 10 stops clocks and outputs only
// - Code 11 resets datapath, spares control port
// - Control port reset by power-on reset; chip select high clears its bit count
// - Enhancement bit 2 enables first-stage chopping
// - Output mode bit 6 picks reduced swing
// - Output mode bit 2 inverts serial stream
// - Output mode bit 0 picks twos complement
// - Output adjust bits 5:4 pick termination
// - Output adjust bit 0 sets clock drive
// - Termination wins over double clock drive
// - Input phase field delays sampling 0..7
// - Output phase field steps 60 degrees
// - User I/O 2 bit 0 disables pull-down
// - Channel status powers down or resets channel
module acrb_regs
  import acrb_pkg::*;
(
  input  wire logic                sys_clk_i,
  input  wire logic                rst_i,
  input  wire logic                spi_sclk_i,
  input  wire logic                spi_csb_n_i,
  input  wire logic                spi_sdio_i,
  output logic                     spi_sdio_o,
  output logic                     spi_sdio_oe_o,
  input  wire logic                power_down_pin_i,
  output logic                     dp_clk_en_o,
  output logic                     dp_rst_o,
  output logic                     out_en_o,
  output logic                     chop_en_o,
  output logic                     ovr_active_o,
  output logic [3:0]               res_bits_o,
  output logic [6:0]               max_rate_msps_o,
  output logic                     sdio_pulldown_dis_o,
  output logic [ACRB_NCH-1:0]      chan_pd_o,
  output logic [ACRB_NCH-1:0]      chan_out_rst_o,
  output logic [ACRB_NCH-1:0]      reduced_swing_o,
  output logic [ACRB_NCH-1:0]      invert_o,
  output logic [ACRB_NCH-1:0]      twos_comp_o,
  output logic [2*ACRB_NCH-1:0]    term_sel_o,
  output logic [ACRB_NCH-1:0]      clk_drive_2x_o,
  output logic [3*ACRB_NCH-1:0]    in_phase_o,
  output logic [4*ACRB_NCH-1:0]    out_phase_o
);

  logic        sclk_d_reg;
  logic [4:0]  cnt_reg;
  logic [15:0] sh_reg;
  logic        rw_reg;
  logic [12:0] addr_reg;
  logic [7:0]  out_sh_reg;
  logic        sdio_o_reg;
  logic        sdio_oe_reg;
  logic        sclk_rise;
  logic        sclk_fall;
  logic [12:0] instr_addr;
  logic [12:0] rd_addr;
  logic [7:0]  wr_data;
  logic        wr_en;
  logic [7:0]  rd_data;

  logic [7:0] chan_idx_reg;
  logic [7:0] power_reg;
  logic [7:0] enh_reg;
  logic [7:0] ser_ctrl_reg;
  logic [7:0] transfer_reg;
  logic [7:0] override_reg;
  logic [7:0] uio2_reg;
  logic [7:0] uio3_reg;
  logic [7:0] sync_reg;
  logic [7:0] out_mode_reg [ACRB_NCH];
  logic [7:0] out_adj_reg  [ACRB_NCH];
  logic [7:0] phase_reg    [ACRB_NCH];
  logic [7:0] status_reg   [ACRB_NCH];

  logic       act_en_reg;
  logic [1:0] act_res_reg;
  logic [2:0] act_rate_reg;
  logic [3:0] res_bits_reg;
  logic [6:0] rate_reg;
  logic [1:0] pm_mode;
  logic       dp_clk_en_reg;
  logic       dp_rst_reg;
  logic       out_en_reg;

  // Serial control port framing
  assign sclk_rise  = spi_sclk_i & ~sclk_d_reg & ~spi_csb_n_i;
  assign sclk_fall  = ~spi_sclk_i & sclk_d_reg & ~spi_csb_n_i;
  assign instr_addr = {sh_reg[11:0], spi_sdio_i};
  assign rd_addr    = (cnt_reg == ACRB_INSTR_LAST) ? instr_addr
                                                   : addr_reg - 13'h0001;
  assign wr_data    = {sh_reg[6:0], spi_sdio_i};
  assign wr_en      = sclk_rise & ~rw_reg & (cnt_reg == ACRB_BYTE_LAST);

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sclk_d_reg <= 1'b0;
    end else begin
      sclk_d_reg <= spi_sclk_i;
    end
  end

  // Port state is cleared by the power-on reset input; chip select high also clears the bit count
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_reg  <= 5'h00;
      sh_reg   <= 16'h0000;
      rw_reg   <= 1'b0;
      addr_reg <= 13'h0000;
    end else if (spi_csb_n_i) begin
      cnt_reg <= 5'h00;
    end else if (sclk_rise) begin
      sh_reg <= {sh_reg[14:0], spi_sdio_i};
      if (cnt_reg == ACRB_INSTR_LAST) begin
        rw_reg   <= sh_reg[14];
        addr_reg <= instr_addr;
      end
      if (cnt_reg == ACRB_BYTE_LAST) begin
        cnt_reg  <= ACRB_BYTE_FIRST;
        addr_reg <= addr_reg - 13'h0001;
      end else begin
        cnt_reg <= cnt_reg + 5'h01;
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      out_sh_reg  <= 8'h00;
      sdio_o_reg  <= 1'b0;
      sdio_oe_reg <= 1'b0;
    end else if (spi_csb_n_i) begin
      sdio_oe_reg <= 1'b0;
    end else if (sclk_rise && (cnt_reg == ACRB_INSTR_LAST ||
                               cnt_reg == ACRB_BYTE_LAST)) begin
      out_sh_reg <= rd_data;
    end else if (sclk_fall && rw_reg && cnt_reg >= ACRB_BYTE_FIRST) begin
      sdio_o_reg  <= out_sh_reg[7];
      sdio_oe_reg <= 1'b1;
      out_sh_reg  <= {out_sh_reg[6:0], 1'b0};
    end
  end

  // Read mux shows lowest selected channel for per-channel registers
  always_comb begin
    int sel;
    sel = 0;
    for (int i = ACRB_NCH - 1; i >= 0; i--) begin
      if (chan_idx_reg[i]) begin
        sel = i;
      end
    end
    case (rd_addr)
      ACRB_ADDR_CHAN_INDEX:  rd_data = chan_idx_reg;
      ACRB_ADDR_POWER_MODES: rd_data = power_reg;
      ACRB_ADDR_ENH_CTRL:    rd_data = enh_reg;
      ACRB_ADDR_OUT_MODE:    rd_data = out_mode_reg[sel];
      ACRB_ADDR_OUT_ADJUST:  rd_data = out_adj_reg[sel];
      ACRB_ADDR_OUT_PHASE:   rd_data = phase_reg[sel];
      ACRB_ADDR_SER_CTRL:    rd_data = ser_ctrl_reg;
      ACRB_ADDR_CHAN_STATUS: rd_data = status_reg[sel];
      ACRB_ADDR_TRANSFER:    rd_data = transfer_reg;
      ACRB_ADDR_OVERRIDE:    rd_data = override_reg;
      ACRB_ADDR_USER_IO2:    rd_data = uio2_reg;
      ACRB_ADDR_USER_IO3:    rd_data = uio3_reg;
      ACRB_ADDR_SYNC:        rd_data = sync_reg;
      default:               rd_data = 8'h00;
    endcase
  end

  // Global registers take effect at the end of the write
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      chan_idx_reg <= ACRB_RST_CHAN_INDEX;
      power_reg    <= ACRB_RST_ZERO;
      enh_reg      <= ACRB_RST_ZERO;
      ser_ctrl_reg <= ACRB_RST_SER_CTRL;
      override_reg <= ACRB_RST_ZERO;
      uio2_reg     <= ACRB_RST_ZERO;
      uio3_reg     <= ACRB_RST_ZERO;
      sync_reg     <= ACRB_RST_ZERO;
    end else if (wr_en) begin
      case (addr_reg)
        ACRB_ADDR_CHAN_INDEX:  chan_idx_reg <= wr_data;
        ACRB_ADDR_POWER_MODES: power_reg    <= wr_data;
        ACRB_ADDR_ENH_CTRL:    enh_reg      <= wr_data;
        ACRB_ADDR_SER_CTRL:    ser_ctrl_reg <= wr_data;
        ACRB_ADDR_OVERRIDE:    override_reg <= wr_data;
        ACRB_ADDR_USER_IO2:    uio2_reg     <= wr_data;
        ACRB_ADDR_USER_IO3:    uio3_reg     <= wr_data;
        ACRB_ADDR_SYNC:        sync_reg     <= wr_data;
        default:               chan_idx_reg <= chan_idx_reg;
      endcase
    end
  end

  // Per-channel registers follow the channel selection
  for (genvar gi = 0; gi < ACRB_NCH; gi++) begin : g_chan
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
        out_mode_reg[gi] <= ACRB_RST_OUT_MODE;
        out_adj_reg[gi]  <= ACRB_RST_ZERO;
        phase_reg[gi]    <= ACRB_RST_ZERO;
        status_reg[gi]   <= ACRB_RST_ZERO;
      end else if (wr_en && chan_idx_reg[gi]) begin
        case (addr_reg)
          ACRB_ADDR_OUT_MODE:    out_mode_reg[gi] <= wr_data;
          ACRB_ADDR_OUT_ADJUST:  out_adj_reg[gi]  <= wr_data;
          ACRB_ADDR_OUT_PHASE:   phase_reg[gi]    <= wr_data;
          ACRB_ADDR_CHAN_STATUS: status_reg[gi]   <= wr_data;
          default:               status_reg[gi]   <= status_reg[gi];
        endcase
      end
    end
    assign reduced_swing_o[gi] = out_mode_reg[gi][ACRB_SWING_BIT];
    assign invert_o[gi]        = out_mode_reg[gi][ACRB_INVERT_BIT];
    assign twos_comp_o[gi]     = out_mode_reg[gi][ACRB_TWOS_BIT];
    assign term_sel_o[2*gi +: 2] = out_adj_reg[gi][5:4];
    assign in_phase_o[3*gi +: 3] = phase_reg[gi][6:4];
    assign out_phase_o[4*gi +: 4] = phase_reg[gi][3:0];
    assign chan_pd_o[gi]      = status_reg[gi][ACRB_CH_PD_BIT];
    assign chan_out_rst_o[gi] = status_reg[gi][ACRB_CH_RST_BIT];
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
        clk_drive_2x_o[gi] <= 1'b0;
      end else begin
        clk_drive_2x_o[gi] <= out_adj_reg[gi][ACRB_DRIVE_BIT] &
                              (out_adj_reg[gi][5:4] == 2'b00);
      end
    end
  end

  // Transfer strobe, cleared on the same edge that applies it
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      transfer_reg <= ACRB_RST_ZERO;
    end else if (wr_en && addr_reg == ACRB_ADDR_TRANSFER) begin
      transfer_reg <= {7'h00, wr_data[ACRB_XFER_BIT]};
    end else begin
      transfer_reg <= ACRB_RST_ZERO;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      act_en_reg   <= 1'b0;
      act_res_reg  <= 2'b00;
      act_rate_reg <= 3'b000;
    end else if (transfer_reg[ACRB_XFER_BIT]) begin
      act_en_reg   <= override_reg[ACRB_OVR_EN_BIT];
      act_res_reg  <= override_reg[5:4];
      act_rate_reg <= override_reg[2:0];
    end
  end

  // Capability limits only; sampling clock is untouched
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      res_bits_reg <= ACRB_BITS_14;
      rate_reg     <= ACRB_RATE_MAX;
    end else begin
      res_bits_reg <= (act_en_reg && act_res_reg == ACRB_RES_12) ?
                      ACRB_BITS_12 : ACRB_BITS_14;
      if (!act_en_reg) begin
        rate_reg <= ACRB_RATE_MAX;
      end else begin
        case (act_rate_reg)
          3'h0:    rate_reg <= 7'h14;
          3'h1:    rate_reg <= 7'h28;
          3'h2:    rate_reg <= 7'h32;
          3'h3:    rate_reg <= 7'h41;
          3'h4:    rate_reg <= 7'h50;
          3'h5:    rate_reg <= 7'h69;
          default: rate_reg <= ACRB_RATE_MAX;
        endcase
      end
    end
  end

  // Power mode decode; pin overrides the internal field
  always_comb begin
    if (power_down_pin_i) begin
      pm_mode = power_reg[ACRB_PIN_STBY] ? ACRB_PM_STANDBY : ACRB_PM_FULL_PD;
    end else begin
      pm_mode = power_reg[1:0];
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      dp_clk_en_reg <= 1'b1;
      dp_rst_reg    <= 1'b0;
      out_en_reg    <= 1'b1;
    end else begin
      case (pm_mode)
        ACRB_PM_NORMAL: begin
          dp_clk_en_reg <= 1'b1;
          dp_rst_reg    <= 1'b0;
          out_en_reg    <= 1'b1;
        end
        ACRB_PM_FULL_PD: begin
          dp_clk_en_reg <= 1'b0;
          dp_rst_reg    <= 1'b1;
          out_en_reg    <= 1'b0;
        end
        ACRB_PM_STANDBY: begin
          dp_clk_en_reg <= 1'b0;
          dp_rst_reg    <= 1'b0;
          out_en_reg    <= 1'b0;
        end
        default: begin
          dp_clk_en_reg <= 1'b1;
          dp_rst_reg    <= 1'b1;
          out_en_reg    <= 1'b0;
        end
      endcase
    end
  end

  assign spi_sdio_o          = sdio_o_reg;
  assign spi_sdio_oe_o       = sdio_oe_reg;
  assign dp_clk_en_o         = dp_clk_en_reg;
  assign dp_rst_o            = dp_rst_reg;
  assign out_en_o            = out_en_reg;
  assign chop_en_o           = enh_reg[ACRB_CHOP_BIT];
  assign ovr_active_o        = act_en_reg;
  assign res_bits_o          = res_bits_reg;
  assign max_rate_msps_o     = rate_reg;
  assign sdio_pulldown_dis_o = uio2_reg[ACRB_PULLDN_BIT];

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  AST_GLOBAL_WRITE: assert property (
    wr_en && addr_reg == ACRB_ADDR_POWER_MODES |=>
      power_reg == $past(wr_data))
    else $error("power register did not take written value");
  AST_XFER_COPY: assert property (
    transfer_reg[ACRB_XFER_BIT] |=>
      act_res_reg == $past(override_reg[5:4]) &&
      act_rate_reg == $past(override_reg[2:0]))
    else $error("transfer did not copy override");
  AST_NO_XFER_HOLD: assert property (
    !transfer_reg[ACRB_XFER_BIT] |=> $stable(act_rate_reg))
    else $error("active rate changed without transfer");
  AST_XFER_CLEAR: assert property (
    transfer_reg[ACRB_XFER_BIT] |=> transfer_reg == 8'h00)
    else $error("transfer bit did not clear");
  AST_RES_12: assert property (
    act_en_reg && act_res_reg == ACRB_RES_12 |=> res_bits_o == 4'hC)
    else $error("resolution limit not 12 bits");
  AST_RATE_20: assert property (
    act_en_reg && act_rate_reg == 3'h0 |=> max_rate_msps_o == 7'h14)
    else $error("rate code 000 not 20 MSPS");
  AST_CHAN_SEL: assert property (
    wr_en && addr_reg == ACRB_ADDR_OUT_MODE && !chan_idx_reg[0] |=>
      $stable(out_mode_reg[0]))
    else $error("unselected channel was written");
  AST_PIN_STBY: assert property (
    power_down_pin_i && power_reg[ACRB_PIN_STBY] |=>
      !dp_clk_en_o && !dp_rst_o && !out_en_o)
    else $error("pin did not enter standby");
  AST_FULL_PD: assert property (
    !power_down_pin_i && power_reg[1:0] == 2'b01 |=>
      !dp_clk_en_o && dp_rst_o && !out_en_o)
    else $error("full power-down outputs wrong");
  AST_PORT_ALIVE: assert property (
    power_reg[1:0] == 2'b11 && wr_en |=> cnt_reg == ACRB_BYTE_FIRST)
    else $error("control port disturbed by digital reset");
  AST_TERM_WINS: assert property (
    out_adj_reg[0][5:4] != 2'b00 |=> !clk_drive_2x_o[0])
    else $error("double drive active with termination");

  COV_XFER: cover property (
    wr_en && addr_reg == ACRB_ADDR_TRANSFER ##2 act_en_reg);
  COV_READ: cover property (sdio_oe_reg && rw_reg);
  COV_DIG_RST: cover property (dp_rst_o && dp_clk_en_o);
endmodule : acrb_regs
`default_nettype wire

// ### include/acrb_pkg.sv
`default_nettype none
package acrb_pkg;
  localparam logic [12:0] ACRB_ADDR_CHAN_INDEX  = 13'h0005;
  localparam logic [12:0] ACRB_ADDR_POWER_MODES = 13'h0008;
  localparam logic [12:0] ACRB_ADDR_ENH_CTRL    = 13'h000C;
  localparam logic [12:0] ACRB_ADDR_OUT_MODE    = 13'h0014;
  localparam logic [12:0] ACRB_ADDR_OUT_ADJUST  = 13'h0015;
  localparam logic [12:0] ACRB_ADDR_OUT_PHASE   = 13'h0016;
  localparam logic [12:0] ACRB_ADDR_SER_CTRL    = 13'h0021;
  localparam logic [12:0] ACRB_ADDR_CHAN_STATUS = 13'h0022;
  localparam logic [12:0] ACRB_ADDR_TRANSFER    = 13'h00FF;
  localparam logic [12:0] ACRB_ADDR_OVERRIDE    = 13'h0100;
  localparam logic [12:0] ACRB_ADDR_USER_IO2    = 13'h0101;
  localparam logic [12:0] ACRB_ADDR_USER_IO3    = 13'h0102;
  localparam logic [12:0] ACRB_ADDR_SYNC        = 13'h0109;

  localparam logic [7:0] ACRB_RST_CHAN_INDEX = 8'h0F;
  localparam logic [7:0] ACRB_RST_OUT_MODE   = 8'h01;
  localparam logic [7:0] ACRB_RST_SER_CTRL   = 8'h30;
  localparam logic [7:0] ACRB_RST_ZERO       = 8'h00;

  localparam int ACRB_NCH = 4;
  localparam logic [4:0] ACRB_INSTR_LAST = 5'h0F;
  localparam logic [4:0] ACRB_BYTE_FIRST = 5'h10;
  localparam logic [4:0] ACRB_BYTE_LAST  = 5'h17;

  localparam int ACRB_XFER_BIT   = 0;
  localparam int ACRB_PIN_STBY   = 5;
  localparam int ACRB_CHOP_BIT   = 2;
  localparam int ACRB_SWING_BIT  = 6;
  localparam int ACRB_INVERT_BIT = 2;
  localparam int ACRB_TWOS_BIT   = 0;
  localparam int ACRB_DRIVE_BIT  = 0;
  localparam int ACRB_OVR_EN_BIT = 6;
  localparam int ACRB_PULLDN_BIT = 0;
  localparam int ACRB_CH_PD_BIT  = 0;
  localparam int ACRB_CH_RST_BIT = 1;

  localparam logic [1:0] ACRB_RES_14 = 2'h1;
  localparam logic [1:0] ACRB_RES_12 = 2'h2;
  localparam logic [3:0] ACRB_BITS_14 = 4'hE;
  localparam logic [3:0] ACRB_BITS_12 = 4'hC;
  localparam logic [6:0] ACRB_RATE_MAX = 7'h7D;

  typedef enum logic [1:0] {
    ACRB_PM_NORMAL  = 2'b00,
    ACRB_PM_FULL_PD = 2'b01,
    ACRB_PM_STANDBY = 2'b10,
    ACRB_PM_DIG_RST = 2'b11
  } acrb_pm_e;
endpackage : acrb_pkg
`default_nettype wire

// ### verification/acrb_host_model.sv
`default_nettype none
module acrb_host_model (
  input  wire logic sys_clk_i,
  output logic      sclk_o,
  output logic      csb_n_o,
  output logic      sdio_o,
  output logic      sdio_oe_o,
  input  wire logic sdio_i
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    sclk_o = 1'b0;
    csb_n_o = 1'b1;
    sdio_o = 1'b0;
    sdio_oe_o = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask : wait_clk

  // One serial bit: data set while clock low, captured on the rise
  task automatic bit_cycle(input logic d, input logic drv, output logic q);
    sclk_o = 1'b0;
    sdio_oe_o = drv;
    sdio_o = drv ? d : ~d;
    wait_clk(3);
    q = sdio_i;
    sclk_o = 1'b1;
    wait_clk(3);
  endtask : bit_cycle

  // Instruction of two bytes, then one data byte, MSB first
  task automatic xfer(input logic rd, input logic [12:0] addr,
                      input logic [7:0] wd, output logic [7:0] rdv);
    logic [23:0] frame;
    logic        q;
    frame = {rd, 2'h0, addr, wd};
    csb_n_o = 1'b0;
    wait_clk(2);
    for (int i = 23; i >= 0; i--) begin
      bit_cycle(frame[i], !(rd && i < 8), q);
      if (i < 8) rdv[i] = q;
    end
    sclk_o = 1'b0;
    wait_clk(2);
    csb_n_o = 1'b1;
    sdio_oe_o = 1'b0;
    wait_clk(3);
  endtask : xfer

  // Write frame cut short after n bits; the port must drop it
  task automatic cut(input logic [12:0] addr, input logic [7:0] wd,
                     input int n);
    logic [23:0] frame;
    logic        q;
    frame = {1'b0, 2'h0, addr, wd};
    csb_n_o = 1'b0;
    wait_clk(2);
    for (int i = 23; i > 23 - n; i--) begin
      bit_cycle(frame[i], 1'b1, q);
    end
    sclk_o = 1'b0;
    wait_clk(2);
    csb_n_o = 1'b1;
    sdio_oe_o = 1'b0;
    wait_clk(3);
  endtask : cut
endmodule : acrb_host_model
`default_nettype wire

// ### verification/adc_control_register_bank_tb.sv
`default_nettype none
module adc_control_register_bank_tb;
  import acrb_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic        sys_clk, rst, pd_pin, sclk, csb_n, host_d, host_oe;
  logic        sdo, sdo_oe, clk_en, dp_rst, out_en, chop, ovr_act;
  logic        pd_dis, sdio_w;
  logic        float_t = 1'b0;
  logic [3:0]  res_bits, chan_pd, chan_rst, swing, inv, twos, drv2x;
  logic [3:0]  mask, exp_res;
  logic [6:0]  rate, exp_rate;
  logic [7:0]  term, rd, v;
  logic [11:0] in_ph;
  logic [15:0] out_ph;
  logic [7:0]  loc [4][4];
  int          num_errors, n_checks;
  integer      seed;

  // Pull-down holds the pin low; with it off the pin floats
  assign sdio_w = sdo_oe ? sdo : host_oe ? host_d : (pd_dis ? float_t : 1'b0);

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) float_t <= ~float_t;

  acrb_host_model host (.sys_clk_i(sys_clk), .sclk_o(sclk), .csb_n_o(csb_n),
    .sdio_o(host_d), .sdio_oe_o(host_oe), .sdio_i(sdio_w));

  acrb_regs uut (.sys_clk_i(sys_clk), .rst_i(rst), .spi_sclk_i(sclk),
    .spi_csb_n_i(csb_n), .spi_sdio_i(sdio_w), .spi_sdio_o(sdo),
    .spi_sdio_oe_o(sdo_oe), .power_down_pin_i(pd_pin),
    .dp_clk_en_o(clk_en), .dp_rst_o(dp_rst), .out_en_o(out_en),
    .chop_en_o(chop), .ovr_active_o(ovr_act), .res_bits_o(res_bits),
    .max_rate_msps_o(rate), .sdio_pulldown_dis_o(pd_dis),
    .chan_pd_o(chan_pd), .chan_out_rst_o(chan_rst),
    .reduced_swing_o(swing), .invert_o(inv), .twos_comp_o(twos),
    .term_sel_o(term), .clk_drive_2x_o(drv2x), .in_phase_o(in_ph),
    .out_phase_o(out_ph));

  function automatic logic [6:0] rate_of(input logic [2:0] c);
    case (c)
      3'h0: return 7'h14;
      3'h1: return 7'h28;
      3'h2: return 7'h32;
      3'h3: return 7'h41;
      3'h4: return 7'h50;
      3'h5: return 7'h69;
      default: return ACRB_RATE_MAX;
    endcase
  endfunction : rate_of

  // Clock enable, datapath reset, output enable per power mode
  function automatic logic [2:0] pm_exp(input logic [1:0] m);
    case (m)
      2'h0: return 3'h5;
      2'h1: return 3'h2;
      2'h2: return 3'h0;
      default: return 3'h6;
    endcase
  endfunction : pm_exp

  function automatic logic [12:0] addr_of(input int k);
    case (k)
      0: return ACRB_ADDR_OUT_MODE;
      1: return ACRB_ADDR_OUT_ADJUST;
      2: return ACRB_ADDR_OUT_PHASE;
      default: return ACRB_ADDR_CHAN_STATUS;
    endcase
  endfunction : addr_of

  task automatic check(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick

  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    host.xfer(1'b0, a, d, rd);
  endtask : wr

  task automatic rdr(input logic [12:0] a);
    host.xfer(1'b1, a, 8'h00, rd);
  endtask : rdr

  task automatic wr_loc(input int k, input logic [7:0] d);
    wr(addr_of(k), d);
    for (int ch = 0; ch < ACRB_NCH; ch++) begin
      if (mask[ch]) loc[k][ch] = d;
    end
  endtask : wr_loc

  task automatic check_loc();
    for (int c = 0; c < ACRB_NCH; c++) begin
      check("swing", swing[c], loc[0][c][6]);
      check("invert", inv[c], loc[0][c][2]);
      check("twos", twos[c], loc[0][c][0]);
      check("term", term[2*c+:2], loc[1][c][5:4]);
      check("drv2x", drv2x[c], loc[1][c][0] & ~|loc[1][c][5:4]);
      check("in_ph", in_ph[3*c+:3], loc[2][c][6:4]);
      check("out_ph", out_ph[4*c+:4], loc[2][c][3:0]);
      check("ch_pd", chan_pd[c], loc[3][c][0]);
      check("ch_rst", chan_rst[c], loc[3][c][1]);
    end
  endtask : check_loc

  task automatic final_report();
    $display("Checks made %0d, mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report

  initial begin
    #500000;
    num_errors++;
    final_report();
  end

  initial begin
    seed = 32'hB7B2;
    num_errors = 0;
    n_checks = 0;
    rst = 1'b1;
    pd_pin = 1'b0;
    mask = 4'hF;
    exp_res = ACRB_BITS_14;
    exp_rate = ACRB_RATE_MAX;
    for (int k = 0; k < 4; k++) begin
      for (int c = 0; c < 4; c++) loc[k][c] = (k == 0) ? 8'h01 : 8'h00;
    end
    tick(6);
    rst = 1'b0;
    tick(2);
    rdr(ACRB_ADDR_CHAN_INDEX);
    check("chan_idx", rd, ACRB_RST_CHAN_INDEX);
    rdr(ACRB_ADDR_SER_CTRL);
    check("ser_ctrl", rd, ACRB_RST_SER_CTRL);
    rdr(ACRB_ADDR_OVERRIDE);
    check("override", rd, ACRB_RST_ZERO);
    rdr(13'h0003);
    check("unmapped", rd, 8'h00);
    check("pm_rst", {clk_en, dp_rst, out_en}, pm_exp(2'h0));
    check_loc();
    $display("Test reset values done");
    for (int r = 0; r < 4; r++) begin
      v = 8'($random(seed));
      wr(ACRB_ADDR_ENH_CTRL, v);
      wr(ACRB_ADDR_USER_IO2, v);
      wr(ACRB_ADDR_SER_CTRL, v);
      tick(1);
      check("chop", chop, v[2]);
      check("pulldn", pd_dis, v[0]);
      rdr(ACRB_ADDR_SER_CTRL);
      check("ser_rd", rd, v);
    end
    host.cut(ACRB_ADDR_SER_CTRL, ~v, 23);
    rdr(ACRB_ADDR_SER_CTRL);
    check("ser_cut", rd, v);
    $display("Test global registers done");
    wr(13'h000B, 8'h07);
    for (int r = 0; r < 10; r++) begin
      mask = (r == 0) ? 4'h1 : (r == 1) ? 4'h8 : 4'($random(seed));
      wr(ACRB_ADDR_CHAN_INDEX, {4'h0, mask});
      wr_loc(0, 8'($random(seed)));
      v = 8'($random(seed));
      if (r % 2 == 1) v[5:4] = 2'h0;
      wr_loc(1, v);
      wr_loc(2, 8'($random(seed)));
      wr_loc(3, 8'($random(seed)));
      tick(2);
      check_loc();
    end
    $display("Test channel registers done");
    for (int c = 0; c < 7; c++) begin
      v = {2'h1, (c % 2 == 1) ? ACRB_RES_14 : ACRB_RES_12, 1'b0, 3'(c)};
      wr(ACRB_ADDR_OVERRIDE, v);
      tick(3);
      check("res_hold", res_bits, exp_res);
      check("rate_hold", rate, exp_rate);
      wr(ACRB_ADDR_TRANSFER, 8'h01);
      tick(4);
      exp_res = (c % 2 == 1) ? ACRB_BITS_14 : ACRB_BITS_12;
      exp_rate = rate_of(3'(c));
      check("res", res_bits, exp_res);
      check("rate", rate, exp_rate);
      check("ovr_act", ovr_act, 1'b1);
      check("clk_run", clk_en, 1'b1);
      rdr(ACRB_ADDR_TRANSFER);
      check("xfer_rd", rd & 8'h01, 8'h00);
    end
    wr(ACRB_ADDR_OVERRIDE, 8'h25);
    wr(ACRB_ADDR_TRANSFER, 8'h01);
    tick(4);
    check("ovr_off", ovr_act, 1'b0);
    check("res_full", res_bits, ACRB_BITS_14);
    check("rate_full", rate, ACRB_RATE_MAX);
    wr(ACRB_ADDR_OVERRIDE, 8'h77);
    wr(ACRB_ADDR_TRANSFER, 8'h01);
    tick(4);
    check("res_code3", res_bits, ACRB_BITS_14);
    check("rate_code7", rate, ACRB_RATE_MAX);
    check("ovr_on", ovr_act, 1'b1);
    $display("Test override done");
    for (int m = 0; m < 4; m++) begin
      wr(ACRB_ADDR_POWER_MODES, 8'(m));
      tick(2);
      check("pm", {clk_en, dp_rst, out_en}, pm_exp(2'(m)));
      rdr(ACRB_ADDR_POWER_MODES);
      check("pm_rd", rd & 8'h03, 8'(m));
    end
    wr(ACRB_ADDR_POWER_MODES, 8'h20);
    pd_pin = 1'b1;
    tick(2);
    check("pin_stby", {clk_en, dp_rst, out_en}, pm_exp(2'h2));
    wr(ACRB_ADDR_POWER_MODES, 8'h00);
    tick(2);
    check("pin_pd", {clk_en, dp_rst, out_en}, pm_exp(2'h1));
    pd_pin = 1'b0;
    tick(2);
    check("pin_off", {clk_en, dp_rst, out_en}, pm_exp(2'h0));
    $display("Test power modes done");
    final_report();
  end
endmodule : adc_control_register_bank_tb
`default_nettype wire
